/* File: tb_top.sv */
// Bench for the channel multiplexer with a host model on the scan side.
// Registers reached over Avalon-MM; front-end readings driven here.
`timescale 1ns/100ps
module tb_top import tcm_pkg::*;;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic go = 1'b0;
    logic scan;
    tcm_image_s image;
    logic valid;
    tcm_sample_s [TCM_NCH-1:0] smp;
    logic [4:0] adr = 5'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic wait_r;
    logic irq;
    logic [7:0][14:0] mag;
    logic [7:0] neg;
    logic [31:0] d;
    int fail_count = 0;
    int n_compared = 0;
    always #25 ref_clk_i = ~ref_clk_i;
    tcm_channel_mux i_dut(.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .scan_i(scan), .image_o(image),
        .image_valid_o(valid), .samples_i(smp), .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wdat), .avs_byteenable(4'hf), .avs_readdata(rdat), .avs_waitrequest(wait_r), .irq_o(irq));
    tcm_host_model i_host(.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .go_i(go), .scan_o(scan),
        .image_i(image), .image_valid_i(valid), .mag_o(mag), .neg_o(neg));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] v);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        adr <= a;
        wr <= w;
        rd <= !w;
        wdat <= v;
        @(posedge ref_clk_i);
        while (wait_r !== 1'b0 && n < 20) begin
            @(posedge ref_clk_i);
            n++;
        end
        d = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n >= 20) fail_count++;
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(d, exp);
    endtask
    task automatic scans(input int n);
        @(posedge ref_clk_i);
        go <= 1'b1;
        repeat (n) @(posedge ref_clk_i);
        go <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
    endtask
    task automatic rng(input logic [1:0] r, input logic signed [16:0] v, input logic [15:0] exp);
        bus(1'b1, TCM_OFS_RANGE, {30'h0, r});
        smp[0].raw <= v;
        scans(1);
        check(32'(image.data), 32'(exp));
    endtask
    task automatic close_out;
        $display("fail_count=%0d n_compared=%0d", fail_count, n_compared);
        if (fail_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge ref_clk_i);
        fail_count++;
        close_out;
    end
    initial begin
        for (int c = 0; c < TCM_NCH; c++) begin
            smp[c].open = (c == 2);
            smp[c].raw = 17'(c * 100 + 5);
        end
        repeat (6) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        rd_chk(TCM_OFS_CTRL, 32'hff);
        rd_chk(TCM_OFS_RANGE, 32'h0);
        bus(1'b1, 5'h18, 32'hffff_ffff);
        rd_chk(5'h18, 32'h0);
        for (int c = 0; c < TCM_NCH; c++) begin
            scans(1);
            check(32'(image.chan_id), 32'(c));
            check(32'(image.data), 32'(c * 100 + 5));
            check(32'(image.open_flags), 32'h04);
        end
        for (int c = 0; c < TCM_NCH; c++) begin
            check(32'(mag[c]), (c == 2) ? 32'h0 : 32'(c * 100 + 5));
        end
        // Only channels three and six enabled
        bus(1'b1, TCM_OFS_CTRL, 32'h24);
        for (int k = 0; k < 4; k++) begin
            scans(1);
            check(32'(image.chan_id), (k % 2) ? 32'h5 : 32'h2);
        end
        bus(1'b1, TCM_OFS_CTRL, 32'h01);
        rng(2'h1, -17'sd65535, 16'hffff);
        check(32'({neg[0], mag[0]}), 32'hffff);
        rng(2'h1, 17'sd65535, 16'h7fff);
        rng(2'h2, -17'sd10273, 16'ha821);
        rng(2'h0, -17'sd5, 16'h0);
        rng(2'h0, 17'sd65535, 16'hffff);
        rng(2'h3, 17'sd300, 16'h012c);
        bus(1'b1, TCM_OFS_IRQ_STAT, 32'h7);
        bus(1'b1, TCM_OFS_IRQ_MASK, 32'h1);
        repeat (2) @(posedge ref_clk_i);
        check(32'(irq), 32'h0);
        scans(1);
        check(32'(irq), 32'h1);
        rd_chk(TCM_OFS_IRQ_STAT, 32'h3);
        bus(1'b1, TCM_OFS_IRQ_STAT, 32'h1);
        repeat (2) @(posedge ref_clk_i);
        rd_chk(TCM_OFS_IRQ_STAT, 32'h2);
        bus(1'b1, TCM_OFS_IRQ_MASK, 32'h0);
        repeat (2) @(posedge ref_clk_i);
        check(32'(irq), 32'h0);
        smp[0].open <= 1'b1;
        scans(1);
        check(32'(image.open_flags), 32'h05);
        rd_chk(TCM_OFS_IRQ_STAT, 32'h7);
        bus(1'b1, TCM_OFS_CTRL, 32'h0);
        scans(2);
        check(image, 32'h0500_012c);
        rd_chk(TCM_OFS_IRQ_STAT, 32'h7);
        rd_chk(TCM_OFS_IMAGE, 32'h0500_012c);
        rd_chk(TCM_OFS_STATUS, 32'h0014_0008);
        close_out;
    end
endmodule // tb_top

bind tcm_channel_mux tcm_channel_mux_monitor i_mon(.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .scan_i(scan_i),
    .image_o(image_o), .image_valid_o(image_valid_o), .samples_i(samples_i), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq_o(irq_o));

/* File: tcm_channel_mux.sv */
// Top of the thermocouple input channel multiplexer: builds the 32-point
// input image one channel per host scan, with an Avalon-MM register slave.
// Assumes host scan strobes and front-end readings are synchronous to ref_clk_i.
//
// How it works
// - One channel result per host scan
// - Image refreshed on every host scan while any channel is enabled
// - Three-bit channel id, values zero to seven
// - Id zero is channel one, seven channel eight
// - Id sits just above lower data word
// - Eight open flags, channel one lowest
// - Lower word top bit is sign flag in bipolar and temperature ranges
// - Temperature counts are tenths of a degree
// - Bipolar magnitude 0..32767, sign gives polarity
// - Unipolar uses full word, 0..65535
// - Bipolar full scale maps to 32767
// - Disabled channels skipped in rotation
// - Open flag follows open thermocouple circuit
`timescale 1ns/100ps
module tcm_channel_mux
    import tcm_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // Host scan
    input wire logic scan_i,
    output tcm_image_s image_o,
    output logic image_valid_o,
    // Front end
    input wire tcm_sample_s [TCM_NCH-1:0] samples_i,
    // Avalon-MM slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Interrupt
    output logic irq_o
);

    // Next enabled channel after cur, searching upward with wrap
    function automatic logic [TCM_CHW-1:0] next_enabled(input logic [TCM_NCH-1:0] en,
                                                         input logic [TCM_CHW-1:0] cur);
        logic [TCM_CHW-1:0] pick;
        logic found;
        logic [TCM_CHW-1:0] idx;
        pick = cur;
        found = 1'b0;
        for (int k = 1; k <= TCM_NCH; k++) begin
            idx = TCM_CHW'(cur + TCM_CHW'(k));
            if (!found && en[idx]) begin
                pick = idx;
                found = 1'b1;
            end
        end
        return pick;
    endfunction

    // Byte-lane merge for register writes
    function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                               input logic [31:0] wdata,
                                               input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[8*b +: 8] = wdata[8*b +: 8];
            end
        end
        return res;
    endfunction

    // Register state
    logic [7:0] enable_q;
    logic [7:0] enable_d;
    logic [15:0] range_q;
    logic [15:0] range_d;
    logic [TCM_IRQ_W-1:0] irq_stat_q;
    logic [TCM_IRQ_W-1:0] irq_stat_d;
    logic [TCM_IRQ_W-1:0] irq_mask_q;
    logic [TCM_IRQ_W-1:0] irq_mask_d;
    logic irq_q;

    // Image state
    tcm_image_s image_q;
    tcm_image_s image_d;
    logic valid_q;
    logic [TCM_CHW-1:0] chan_q;
    logic [TCM_CHW-1:0] chan_d;
    logic [15:0] scan_count_q;
    logic [TCM_NCH-1:0] open_prev_q;

    // Bus handshake state
    logic ack_q;
    logic ack_d;
    logic wait_q;
    logic [31:0] rdata_q;

    // Rotation decode
    logic any_enabled;
    logic present;
    logic [TCM_CHW-1:0] sel_chan;
    logic wrapped;
    tcm_sample_s sel_sample;
    logic [1:0] sel_range;
    logic [15:0] sel_word;
    logic [TCM_NCH-1:0] open_now;
    logic [TCM_NCH-1:0] open_rise;

    // Bus decode
    logic bus_req;
    logic bus_take;
    logic wr_take;
    logic hit_ctrl;
    logic hit_range;
    logic hit_image;
    logic hit_status;
    logic hit_istat;
    logic hit_imask;
    logic [31:0] rdata_mux;
    logic [31:0] ctrl_word;
    logic [31:0] range_word;
    logic [31:0] status_word;
    logic [31:0] istat_word;
    logic [31:0] imask_word;
    logic [31:0] istat_wr;
    logic [31:0] ctrl_wr;
    logic [31:0] range_wr;
    logic [31:0] imask_wr;
    logic [TCM_IRQ_W-1:0] irq_events;

    // ---------------- Channel rotation ----------------

    assign any_enabled = |enable_q;
    // With nothing enabled the image holds its last contents
    assign present = scan_i && any_enabled;
    // Before the first scan a search from channel eight lands on the lowest enabled one
    assign sel_chan = valid_q ? next_enabled(enable_q, chan_q) : next_enabled(enable_q, 3'h7);
    assign wrapped = valid_q && (sel_chan <= chan_q);
    assign sel_sample = samples_i[sel_chan];
    assign sel_range = range_q[2*sel_chan +: 2];

    tcm_value_encoder u_encoder (
        .raw_i(sel_sample.raw),
        .range_i(sel_range),
        .word_o(sel_word)
    );

    // Open flags of all channels, sampled at the same scan as the data
    generate
        for (genvar c = 0; c < TCM_NCH; c++) begin : g_open
            assign open_now[c] = samples_i[c].open;
            assign open_rise[c] = open_now[c] && !open_prev_q[c];
        end
    endgenerate

    always_comb begin
        image_d = image_q;
        chan_d = chan_q;
        if (present) begin
            // Every field of the image comes from the same scan
            image_d.data = sel_word;
            image_d.chan_id = sel_chan;
            image_d.open_flags = open_now;
            image_d.unused = 5'h00;
            chan_d = sel_chan;
        end
    end

    // Every field of the image shares one register, so no scan is ever half shown
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            image_q <= '0;
        end else begin
            image_q <= image_d;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            chan_q <= TCM_CHAN_RST;
        end else begin
            chan_q <= chan_d;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            valid_q <= 1'b0;
        end else begin
            valid_q <= valid_q | present;
        end
    end

    // Scan count wraps silently; software uses it only to watch progress
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            scan_count_q <= 16'h0000;
        end else begin
            scan_count_q <= present ? 16'(scan_count_q + 16'h0001) : scan_count_q;
        end
    end

    // Open flags of the last presented scan, for the rising-edge event
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            open_prev_q <= '0;
        end else begin
            open_prev_q <= present ? open_now : open_prev_q;
        end
    end

    assign image_o = image_q;
    assign image_valid_o = valid_q;

    // ---------------- Avalon-MM slave ----------------

    // One wait cycle per access; the access completes on the edge where
    // waitrequest is low, and readdata is already loaded at that edge.
    assign bus_req = avs_read || avs_write;
    assign bus_take = bus_req && ack_q;
    assign wr_take = bus_take && avs_write;
    assign ack_d = bus_req && !ack_q;

    assign hit_ctrl = (avs_address == TCM_OFS_CTRL);
    assign hit_range = (avs_address == TCM_OFS_RANGE);
    assign hit_image = (avs_address == TCM_OFS_IMAGE);
    assign hit_status = (avs_address == TCM_OFS_STATUS);
    assign hit_istat = (avs_address == TCM_OFS_IRQ_STAT);
    assign hit_imask = (avs_address == TCM_OFS_IRQ_MASK);

    assign ctrl_word = 32'(enable_q) << TCM_CTRL_EN_LSB;
    assign range_word = {16'h0000, range_q};
    assign status_word = (32'(scan_count_q) << TCM_STAT_COUNT_LSB)
                       | (32'(valid_q) << TCM_STAT_VALID_BIT)
                       | (32'(chan_q) << TCM_STAT_CHAN_LSB);
    assign istat_word = {29'h0, irq_stat_q};
    assign imask_word = {29'h0, irq_mask_q};

    // Unmapped addresses read as zero and ignore writes
    assign rdata_mux = hit_ctrl ? ctrl_word :
                       hit_range ? range_word :
                       hit_image ? 32'(image_q) :
                       hit_status ? status_word :
                       hit_istat ? istat_word :
                       hit_imask ? imask_word : 32'h0000_0000;

    assign ctrl_wr = lane_merge(ctrl_word, avs_writedata, avs_byteenable);
    assign range_wr = lane_merge(range_word, avs_writedata, avs_byteenable);
    assign imask_wr = lane_merge(imask_word, avs_writedata, avs_byteenable);
    // Write-one-to-clear, only on enabled byte lanes
    assign istat_wr = lane_merge(32'h0, avs_writedata, avs_byteenable);

    assign enable_d = (wr_take && hit_ctrl) ? ctrl_wr[TCM_CTRL_EN_LSB +: 8] : enable_q;
    assign range_d = (wr_take && hit_range) ? range_wr[15:0] : range_q;
    assign irq_mask_d = (wr_take && hit_imask) ? imask_wr[TCM_IRQ_W-1:0] : irq_mask_q;

    // ---------------- Interrupts ----------------

    assign irq_events[TCM_IRQ_SCAN_BIT] = present;
    assign irq_events[TCM_IRQ_WRAP_BIT] = present && wrapped;
    assign irq_events[TCM_IRQ_OPEN_BIT] = present && (|open_rise);

    // A new event in the clearing cycle wins over the clear
    assign irq_stat_d = (irq_stat_q & ~((wr_take && hit_istat) ? istat_wr[TCM_IRQ_W-1:0] : '0))
                      | irq_events;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            enable_q <= TCM_ENABLE_RST;
        end else begin
            enable_q <= enable_d;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            range_q <= TCM_RANGE_RST;
        end else begin
            range_q <= range_d;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            irq_mask_q <= TCM_IRQ_MASK_RST;
        end else begin
            irq_mask_q <= irq_mask_d;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= irq_stat_d;
        end
    end

    // Built from next values so the line follows a set or clear without a cycle of lag
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_stat_d & irq_mask_d);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= ack_d;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= !ack_d;
        end
    end

    // Loaded in the wait cycle, so read data already stands at the completing edge
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (ack_d) begin
            rdata_q <= rdata_mux;
        end
    end

    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;
    assign irq_o = irq_q;

endmodule // tcm_channel_mux

/* File: tcm_channel_mux_monitor.sv */
// Port checks for the channel multiplexer.
// Bound into the top; one clock, synchronous active-low reset.
`timescale 1ns/100ps
module tcm_channel_mux_monitor
    import tcm_pkg::*;
(
    // Clock, reset, scan side
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic scan_i,
    input wire tcm_image_s image_o,
    input wire logic image_valid_o,
    input wire tcm_sample_s [TCM_NCH-1:0] samples_i,
    // Bus and interrupt
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic irq_o
);
    logic [TCM_NCH-1:0] open_vec;
    for (genvar c = 0; c < TCM_NCH; c++) begin : g_open
        assign open_vec[c] = samples_i[c].open;
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence bus_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence bus_ack;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    a_image_after_scan: assert property ($changed(image_o) |-> $past(scan_i))
        else $error("image changed without a scan");
    a_open_flags_follow: assert property ($changed(image_o) |-> image_o.open_flags == $past(open_vec))
        else $error("open flags differ from front end");
    a_pad_bits_zero: assert property (image_o.unused == 5'h0)
        else $error("unused image bits set");
    a_valid_after_scan: assert property ($rose(image_valid_o) |-> $past(scan_i))
        else $error("valid rose without a scan");
    a_valid_stays_high: assert property (image_valid_o |=> image_valid_o)
        else $error("valid dropped");
    a_bus_one_wait: assert property (bus_req |=> bus_ack)
        else $error("bus answer not after one wait cycle");
    a_readdata_holds: assert property (avs_waitrequest && $past(avs_waitrequest) |-> $stable(avs_readdata))
        else $error("read data moved while idle");
    a_unmapped_reads_zero: assert property (bus_req and avs_read && (avs_address > 5'h14 || avs_address[1:0] != 2'h0)
        |=> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
endmodule // tcm_channel_mux_monitor

/* File: tcm_host_model.sv */
// Host model: issues scan strobes and demultiplexes the input image.
// Same clock as the device; scans back to back while go_i is high.
`timescale 1ns/100ps
module tcm_host_model
    import tcm_pkg::*;
(
    // Clock, reset, control
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic go_i,
    // Device side
    output logic scan_o,
    input wire tcm_image_s image_i,
    input wire logic image_valid_i,
    // Per-channel results
    output logic [7:0][14:0] mag_o,
    output logic [7:0] neg_o
);
    logic scan_q;
    logic take_w;
    assign take_w = scan_q && image_valid_i && !image_i.open_flags[image_i.chan_id];
    always_ff @(posedge ref_clk_i) begin
        scan_o <= rst_n_i && go_i;
        scan_q <= rst_n_i && scan_o;
        if (!rst_n_i) begin
            mag_o <= '0;
            neg_o <= '0;
        end else if (take_w) begin
            // Sign stored apart, else the magnitude reads wrong
            mag_o[image_i.chan_id] <= image_i.data[14:0];
            neg_o[image_i.chan_id] <= image_i.data[15];
        end
    end
endmodule // tcm_host_model

/* File: tcm_pkg.sv */
// Package for the thermocouple input channel multiplexer.
// Shared by the value encoder and the top module; no clock assumptions.
package tcm_pkg;

    // Channel geometry
    localparam int TCM_NCH = 8;
    localparam int TCM_CHW = 3;

    // Register byte offsets on the Avalon-MM slave
    localparam logic [4:0] TCM_OFS_CTRL = 5'h00;
    localparam logic [4:0] TCM_OFS_RANGE = 5'h04;
    localparam logic [4:0] TCM_OFS_IMAGE = 5'h08;
    localparam logic [4:0] TCM_OFS_STATUS = 5'h0c;
    localparam logic [4:0] TCM_OFS_IRQ_STAT = 5'h10;
    localparam logic [4:0] TCM_OFS_IRQ_MASK = 5'h14;

    // Reset values
    localparam logic [7:0] TCM_ENABLE_RST = 8'hff;
    localparam logic [15:0] TCM_RANGE_RST = 16'h0000;
    localparam logic [2:0] TCM_IRQ_MASK_RST = 3'h0;
    localparam logic [2:0] TCM_CHAN_RST = 3'h0;

    // Field positions
    localparam int TCM_CTRL_EN_LSB = 0;
    localparam int TCM_STAT_CHAN_LSB = 0;
    localparam int TCM_STAT_VALID_BIT = 3;
    localparam int TCM_STAT_COUNT_LSB = 16;
    localparam int TCM_IRQ_W = 3;
    localparam int TCM_IRQ_SCAN_BIT = 0;
    localparam int TCM_IRQ_WRAP_BIT = 1;
    localparam int TCM_IRQ_OPEN_BIT = 2;

    // Count limits of the data word
    localparam logic [15:0] TCM_MAG_MAX_BIPOLAR = 16'h7fff;
    localparam logic [15:0] TCM_MAG_MAX_UNIPOLAR = 16'hffff;

    // Per-channel range selection, two bits per channel
    typedef enum logic [1:0] {
        TCM_RANGE_UNIPOLAR,
        TCM_RANGE_BIPOLAR,
        TCM_RANGE_TEMP
    } tcm_range_e;

    // Front-end reading of one channel
    typedef struct packed {
        logic open;
        logic signed [16:0] raw;
    } tcm_sample_s;

    // The 32-point input image seen by the host
    typedef struct packed {
        logic [7:0] open_flags;
        logic [4:0] unused;
        logic [2:0] chan_id;
        logic [15:0] data;
    } tcm_image_s;

endpackage

/* File: tcm_value_encoder.sv */
// Encodes one front-end reading into the 16-bit data word of the image.
// Purely combinational; the caller registers the result.
`timescale 1ns/100ps
module tcm_value_encoder
    import tcm_pkg::*;
(
    // Reading and range
    input wire logic signed [16:0] raw_i,
    input wire logic [1:0] range_i,
    // Encoded word
    output logic [15:0] word_o
);

    logic neg;
    logic [16:0] mag;
    logic [16:0] mag_half;
    logic [15:0] bip_mag;
    logic [15:0] temp_mag;
    logic [15:0] uni_val;

    assign neg = raw_i[16];
    assign mag = neg ? 17'(-raw_i) : 17'(raw_i);
    // Bipolar full scale of +/-65535 raw maps to 32767 counts
    assign mag_half = mag >> 1;
    assign bip_mag = (mag_half > 17'(TCM_MAG_MAX_BIPOLAR)) ? TCM_MAG_MAX_BIPOLAR : mag_half[15:0];
    // Temperature raw is already in tenths of a degree
    assign temp_mag = (mag > 17'(TCM_MAG_MAX_BIPOLAR)) ? TCM_MAG_MAX_BIPOLAR : mag[15:0];
    // Unipolar has no sign; below-range readings clamp to zero
    assign uni_val = neg ? 16'h0000 : raw_i[15:0];

    always_comb begin
        unique case (range_i)
            TCM_RANGE_UNIPOLAR: word_o = uni_val;
            TCM_RANGE_BIPOLAR: word_o = {neg & (bip_mag != 16'h0000), bip_mag[14:0]};
            TCM_RANGE_TEMP: word_o = {neg & (temp_mag != 16'h0000), temp_mag[14:0]};
            default: word_o = uni_val;
        endcase
    end

endmodule // tcm_value_encoder
